// >>> include/mrs_pkg.sv
// Package: constants and carrier types of the reset sequencer
package mrs_pkg;
  // Clock rate and derived timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned POR_MIN_MS      = 7;
  localparam int unsigned POR_MAX_MS      = 24;
  // Power-on interval sits at its least time, 7 ms as 700000 whole cycles
  localparam int unsigned POR_CYCLES      = POR_MIN_MS * (CLK_HZ / 1000);
  // Watchdog delays in microseconds, indexed by the two mode bits
  localparam int unsigned WD_US_0         = 6250;
  localparam int unsigned WD_US_1         = 12500;
  localparam int unsigned WD_US_2         = 25000;
  localparam int unsigned WD_US_3         = 100000;
  localparam int unsigned WD_CYC_0        = WD_US_0 * (CLK_HZ / 1_000_000);
  localparam int unsigned WD_CYC_1        = WD_US_1 * (CLK_HZ / 1_000_000);
  localparam int unsigned WD_CYC_2        = WD_US_2 * (CLK_HZ / 1_000_000);
  localparam int unsigned WD_CYC_3        = WD_US_3 * (CLK_HZ / 1_000_000);
  // Internal reset stretch and fetch delay
  localparam int unsigned RST_HOLD_CYCLES = 18;
  localparam int unsigned FETCH_DELAY     = 5;
  localparam logic [15:0] FETCH_ADDR      = 16'h000c;
  localparam int unsigned CNT_W           = 24;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    MRS_POR   = 4'h1,
    MRS_HOLD  = 4'h2,
    MRS_WAIT  = 4'h4,
    MRS_RUN   = 4'h8
  } mrs_state_t;

  // Open-drain reset pin as three signals
  typedef struct packed {
    logic out;
    logic oe;
    logic pullup_en;
  } mrs_pin_t;

  // Core-facing start request
  typedef struct packed {
    logic        core_rst;
    logic        fetch_go;
    logic [15:0] fetch_addr;
  } mrs_core_t;
endpackage

// >>> hw/mrs_watchdog.sv
// Watchdog timer: counts to the selected delay, pulses on expiry
`timescale 1ns/1ns
module mrs_watchdog
  import mrs_pkg::*;
#(
  parameter int unsigned W_CYC_0 = WD_CYC_0,
  parameter int unsigned W_CYC_1 = WD_CYC_1,
  parameter int unsigned W_CYC_2 = WD_CYC_2,
  parameter int unsigned W_CYC_3 = WD_CYC_3
) (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       enable_i,
  input  wire logic       kick_i,
  input  wire logic [1:0] watchdog_mode_reg_i,
  output logic            expire_o
);
  import mrs_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             expire;
  } mrs_wd_t;

  mrs_wd_t st;
  mrs_wd_t next_st;

  // Delay select from the two mode bits
  function automatic logic [CNT_W-1:0] wd_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    wd_limit = CNT_W'(W_CYC_0);
      2'h1:    wd_limit = CNT_W'(W_CYC_1);
      2'h2:    wd_limit = CNT_W'(W_CYC_2);
      default: wd_limit = CNT_W'(W_CYC_3);
    endcase
  endfunction

  // Counter; a kick restarts the delay
  always_comb begin
    next_st        = st;
    next_st.expire = 1'b0;
    if (!enable_i || kick_i) begin
      next_st.cnt = '0;
    end else if (st.cnt >= wd_limit(watchdog_mode_reg_i) - 1'b1) begin
      next_st.cnt    = '0;
      next_st.expire = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign expire_o = st.expire;
endmodule

// >>> hw/mrs_reset_seq.sv
// Reset sequencer: merges reset sources, drives pin, starts fetch
`timescale 1ns/1ns

// What this block does
// - Reset from power-on, watchdog or pin.
// - Power-on and watchdog pull pin low.
// - Internal pull-up keeps pin idle high.
// - After interval, pin is input only.
// - Hold internal reset 18 clocks or longer.
// - Fetch from 000C, 5-10 clocks after release.
// - Power-on interval 7 to 24 ms.
// - Two mode bits pick watchdog delay.
module mrs_reset_seq
  import mrs_pkg::*;
#(
  parameter int unsigned POR_CNT  = POR_CYCLES,
  parameter int unsigned WD_C0    = WD_CYC_0,
  parameter int unsigned WD_C1    = WD_CYC_1,
  parameter int unsigned WD_C2    = WD_CYC_2,
  parameter int unsigned WD_C3    = WD_CYC_3,
  parameter int unsigned HOLD_CNT = RST_HOLD_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       rst_pin_n_i,
  input  wire logic       watchdog_en_i,
  input  wire logic       watchdog_kick_i,
  input  wire logic [1:0] watchdog_mode_reg_i,
  output mrs_pkg::mrs_pin_t  rst_pin_o,
  output mrs_pkg::mrs_core_t core_o
);
  import mrs_pkg::*;

  typedef struct packed {
    mrs_state_t       state;
    logic [CNT_W-1:0] cnt;
    logic             drive_low;
    logic             sync1;
    logic             sync2;
    mrs_core_t        core;
  } mrs_seq_t;

  mrs_seq_t st;
  mrs_seq_t next_st;
  logic     wd_expire;

  mrs_watchdog #(
    .W_CYC_0 (WD_C0),
    .W_CYC_1 (WD_C1),
    .W_CYC_2 (WD_C2),
    .W_CYC_3 (WD_C3)
  ) u_wd (
    .clk_i               (clk_i),
    .arst_n_i            (arst_n_i),
    .enable_i            (watchdog_en_i && st.state == MRS_RUN),
    .kick_i              (watchdog_kick_i),
    .watchdog_mode_reg_i (watchdog_mode_reg_i),
    .expire_o            (wd_expire)
  );

  // Sequencer; pin level only read through the second sync stage
  always_comb begin
    next_st               = st;
    next_st.sync1         = rst_pin_n_i;
    next_st.sync2         = st.sync1;
    next_st.core.fetch_go = 1'b0;
    case (st.state)
      MRS_POR: begin
        // Own pull-down lasts the whole power-on interval
        next_st.drive_low = 1'b1;
        next_st.core.core_rst = 1'b1;
        if (st.cnt >= CNT_W'(POR_CNT - 1)) begin
          next_st.cnt       = '0;
          next_st.drive_low = 1'b0;
          next_st.state     = MRS_HOLD;
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      MRS_HOLD: begin
        // Stretch; pin held low restarts nothing but blocks release
        next_st.core.core_rst = 1'b1;
        if (st.cnt < CNT_W'(HOLD_CNT - 1)) begin
          next_st.cnt = st.cnt + 1'b1;
        end else if (st.sync2) begin
          next_st.cnt           = '0;
          next_st.core.core_rst = 1'b0;
          next_st.state         = MRS_WAIT;
        end
      end
      MRS_WAIT: begin
        next_st.core.core_rst = 1'b0;
        if (!st.sync2) begin
          next_st.cnt           = '0;
          next_st.core.core_rst = 1'b1;
          next_st.state         = MRS_HOLD;
        end else if (st.cnt >= CNT_W'(FETCH_DELAY - 1)) begin
          next_st.cnt             = '0;
          next_st.core.fetch_go   = 1'b1;
          next_st.core.fetch_addr = FETCH_ADDR;
          next_st.state           = MRS_RUN;
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      MRS_RUN: begin
        if (wd_expire) begin
          // Watchdog reset reuses the power-on pull-down path
          next_st.cnt           = '0;
          next_st.drive_low     = 1'b1;
          next_st.core.core_rst = 1'b1;
          next_st.state         = MRS_POR;
        end else if (!st.sync2) begin
          next_st.cnt           = '0;
          next_st.core.core_rst = 1'b1;
          next_st.state         = MRS_HOLD;
        end
      end
      default: begin
        next_st.cnt   = '0;
        next_st.state = MRS_POR;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st                 <= '0;
      st.state           <= MRS_POR;
      st.drive_low       <= 1'b1;
      st.sync1           <= 1'b1;
      st.sync2           <= 1'b1;
      st.core.core_rst   <= 1'b1;
      st.core.fetch_addr <= FETCH_ADDR;
    end else begin
      st <= next_st;
    end
  end

  // Open-drain: only ever drive low, never high
  assign rst_pin_o.out       = 1'b0;
  assign rst_pin_o.oe        = st.drive_low;
  assign rst_pin_o.pullup_en = 1'b1;
  assign core_o              = st.core;

  // Checks; the pin sense is only ever read after both sync stages
  sequence s_release;
    $fell(core_o.core_rst);
  endsequence

  // Synced pin stays high for the whole fetch delay
  sequence s_pin_quiet;
    st.sync2[*5];
  endsequence

  // Minimum stretch, one sample per clock; split so each repeat stays short
  sequence s_hold_full;
    core_o.core_rst[*8] ##1 core_o.core_rst[*8] ##1 core_o.core_rst[*2];
  endsequence

  // Pin pulled low again before the fetch has started
  sequence s_wait_abort;
    st.state == MRS_WAIT && !st.sync2;
  endsequence

  // Expiry taken while running
  sequence s_wd_fire;
    st.state == MRS_RUN && wd_expire;
  endsequence

  // Pin reset while running; expiry has priority over it
  sequence s_pin_run;
    st.state == MRS_RUN && !st.sync2 && !wd_expire;
  endsequence

  // Pin ownership
  a_por_pin_low: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    st.state == MRS_POR |-> rst_pin_o.oe)
    else $error("pin not pulled low during power-on interval");
  a_pin_released: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    st.state == MRS_RUN |-> !rst_pin_o.oe)
    else $error("pin still driven after interval");
  a_pin_free_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (st.state == MRS_HOLD || st.state == MRS_WAIT) |-> !rst_pin_o.oe)
    else $error("pin driven during stretch or fetch delay");
  a_pullup_on: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    rst_pin_o.pullup_en && !rst_pin_o.out)
    else $error("pin pull-up off or driven high");

  // Core reset stretch and release
  a_hold_min: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(core_o.core_rst) |-> s_hold_full)
    else $error("internal reset shorter than minimum");
  a_pin_extends: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (st.state == MRS_HOLD && !st.sync2) |=> core_o.core_rst)
    else $error("reset released while pin low");
  a_release_pin_high: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_release |-> $past(st.sync2))
    else $error("internal reset released on a low pin");
  a_por_core_held: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    st.state == MRS_POR |-> core_o.core_rst)
    else $error("core free during power-on interval");
  a_run_core_free: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    st.state == MRS_RUN |-> !core_o.core_rst)
    else $error("core held in reset while running");
  a_wait_abort: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_wait_abort |=> core_o.core_rst && st.state == MRS_HOLD)
    else $error("pin reset during fetch delay not taken");

  // Fetch start
  a_fetch_delay: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_release ##0 s_pin_quiet |-> ##[1:6] core_o.fetch_go)
    else $error("fetch not started 5-10 clocks after release");
  a_fetch_addr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    core_o.fetch_go |-> core_o.fetch_addr == 16'h000c)
    else $error("fetch address wrong");
  a_fetch_once: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    core_o.fetch_go |=> !core_o.fetch_go)
    else $error("fetch start longer than one clock");

  // Reset sources while running
  a_wd_reset: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_wd_fire |=> rst_pin_o.oe && core_o.core_rst)
    else $error("watchdog expiry did not reset");
  a_pin_reset: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_pin_run |=> core_o.core_rst)
    else $error("pin reset not taken");
endmodule

// >>> sim/mrs_ext_drv.sv
// Outside open-drain party that shares the reset line
`timescale 1ns/1ns
module mrs_ext_drv (
  input  wire logic clk_i,
  output logic      pull_low_o
);
  // Only pulls low or lets go, never drives high
  initial pull_low_o = 1'b0;
  task automatic pull(input int unsigned n);
    @(posedge clk_i);
    pull_low_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    pull_low_o <= 1'b0;
  endtask
endmodule

// >>> sim/tb_mcu_reset_sequencer.sv
// Testbench of the reset sequencer with an outside reset driver
`timescale 1ns/1ns
module tb_mcu_reset_sequencer;
  import mrs_pkg::*;
  localparam int unsigned POR = 50;
  logic       clk_i    = 1'b0;
  logic       arst_n_i = 1'b0;
  logic       wd_en    = 1'b0;
  logic       kick     = 1'b0;
  logic [1:0] mode     = 2'h0;
  logic       ext_low;
  mrs_pin_t   pin_o;
  mrs_core_t  core;
  int         mismatches = 0;
  int         cmp_count  = 0;
  int         cyc        = 0;
  int         n;
  int         hi;
  // Resolved line: device level while it drives, else pull-up; outside only pulls low
  wire pin = (pin_o.oe ? pin_o.out : pin_o.pullup_en) & ~ext_low;

  mrs_reset_seq #(.POR_CNT(POR), .WD_C0(40), .WD_C1(60), .WD_C2(80), .WD_C3(100),
    .HOLD_CNT(18)) DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .rst_pin_n_i(pin),
    .watchdog_en_i(wd_en), .watchdog_kick_i(kick), .watchdog_mode_reg_i(mode),
    .rst_pin_o(pin_o), .core_o(core));
  mrs_ext_drv EXT (.clk_i(clk_i), .pull_low_o(ext_low));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // Hang guard, well above the roughly 1000 cycles of the run
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic chk(input logic got, input logic exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic chk_addr(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t fetch address %h", $time, got);
    end
  endtask

  task automatic chk_cnt(input int got, input int lo, input int up, input string msg);
    cmp_count++;
    if (got < lo || got > up) begin
      mismatches++;
      $display("CHECK FAILED %0t %s count %0d", $time, msg, got);
    end
  endtask

  // Counts the rest of core reset, then the gap to the fetch pulse
  task automatic seq(output int h);
    h = 0;
    while (core.core_rst === 1'b1 && h < 2000) begin
      @(negedge clk_i);
      h++;
    end
    n = 0;
    while (core.fetch_go !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    chk_cnt(n, 5, 10, "fetch delay");
    chk_addr(core.fetch_addr, 16'h000c);
  endtask

  // Power-on interval: pin pulled low throughout, then released
  task automatic t_por();
    n = 0;
    while (pin_o.oe === 1'b1 && n < 1000) begin
      chk(pin | ~core.core_rst, 1'b0, "pin or core reset not held");
      @(negedge clk_i);
      n++;
    end
    chk_cnt(n, POR - 1, POR + 2, "power-on interval");
    chk(pin, 1'b1, "pin not idle high");
    seq(hi);
    chk_cnt(hi, 18, 22, "stretch after interval");
    $display("test power-on done");
  endtask

  // Outside pin reset of a given length, long or short
  task automatic t_ext(input int len);
    int exp;
    exp = (len > 18) ? len : 18;
    fork
      EXT.pull(len);
    join_none
    repeat (5) @(negedge clk_i);
    chk(core.core_rst, 1'b1, "pin reset not taken");
    chk(pin_o.oe, 1'b0, "device drove pin");
    seq(hi);
    chk_cnt(hi + 5, exp + 1, exp + 8, "pin reset stretch");
    $display("test pin reset %0d done", len);
  endtask

  // Pin pulled again inside the fetch delay: back to hold, no fetch
  task automatic t_abort();
    fork
      EXT.pull(3);
    join_none
    repeat (5) @(negedge clk_i);
    chk(core.core_rst, 1'b1, "first pin reset not taken");
    hi = 0;
    while (core.core_rst === 1'b1 && hi < 100) begin
      @(negedge clk_i);
      hi++;
    end
    fork
      EXT.pull(3);
    join_none
    n = 0;
    while (core.core_rst !== 1'b1 && n < 20) begin
      chk(core.fetch_go, 1'b0, "fetch despite pin low");
      @(negedge clk_i);
      n++;
    end
    chk_cnt(n, 3, 5, "pin reset in fetch delay");
    seq(hi);
    chk_cnt(hi, 18, 22, "stretch after second pull");
    $display("test pin reset in fetch delay done");
  endtask

  // Kicked watchdog never fires
  task automatic t_kick();
    @(posedge clk_i);
    wd_en <= 1'b1;
    kick  <= 1'b1;
    repeat (150) @(negedge clk_i);
    chk(core.core_rst | pin_o.oe, 1'b0, "kicked watchdog fired");
    @(posedge clk_i);
    kick <= 1'b0;
    $display("test kick done");
  endtask

  // Each delay select fires a full power-on sequence
  task automatic t_wdog();
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_i);
      mode <= m[1:0];
      n = 1;
      while (pin_o.oe !== 1'b1 && n < 300) begin
        @(negedge clk_i);
        n++;
      end
      chk_cnt(n, (m == 3) ? 98 : 38 + 20 * m, (m == 3) ? 105 : 45 + 20 * m,
              "watchdog delay");
      chk(core.core_rst, 1'b1, "watchdog reset missing");
      t_por();
    end
    $display("test watchdog done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(negedge clk_i);
    t_por();
    t_ext(40);
    t_ext(3);
    t_abort();
    t_kick();
    t_wdog();
    print_verdict();
  end
endmodule
